/* File: accel_check_pkg.sv */
// Purpose: Shared constants for the acceleration parameter checker
// Assumes: 20 MHz clock, APB register access with 32-bit data
// Notes:   Speeds in pps, transition times in 10 ms steps
package accel_check_pkg;
   localparam int SPEED_W = 16;
   localparam int ACC_W   = 12;
   localparam int ADDR_W  = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_PROPERTY_GROUP_TWO = 8'h00;
   localparam logic [7:0] OFS_LOWER_SPEED        = 8'h04;
   localparam logic [7:0] OFS_UPPER_SPEED        = 8'h08;
   localparam logic [7:0] OFS_RISE_SETTING       = 8'h0C;
   localparam logic [7:0] OFS_FALL_SETTING       = 8'h10;
   localparam logic [7:0] OFS_INSTRUCTION        = 8'h14;
   localparam logic [7:0] OFS_STATUS             = 8'h18;
   localparam logic [7:0] OFS_IRQ_STATUS         = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK           = 8'h20;
   localparam logic [7:0] OFS_EFFECTIVE_BASE     = 8'h30;
   localparam logic [7:0] EFFECTIVE_MASK         = 8'hF0;

   // Property group two fields
   localparam int BIT_FORMAT_SELECT = 0;
   localparam int BIT_AUTO_CORRECT  = 1;
   localparam int RANGE_LSB         = 2;
   localparam logic [1:0] RANGE_DEFAULT = 2'h2;

   // Speed ranges, pps
   localparam logic [SPEED_W-1:0] RANGE0_MIN = 16'h000A; // 10
   localparam logic [SPEED_W-1:0] RANGE0_MAX = 16'h09C4; // 2500
   localparam logic [SPEED_W-1:0] RANGE1_MIN = 16'h0028; // 40
   localparam logic [SPEED_W-1:0] RANGE1_MAX = 16'h2710; // 10000
   localparam logic [SPEED_W-1:0] RANGE2_MIN = 16'h00A0; // 160
   localparam logic [SPEED_W-1:0] RANGE2_MAX = 16'h30D4; // 12500

   // Required-time format limits, counts of 10 ms
   localparam int TIME_STEP_MS = 10;
   localparam logic [ACC_W-1:0] TIME_MIN_ANY = 12'h008;
   localparam logic [ACC_W-1:0] TIME_MIN_11K = 12'h007;
   localparam logic [ACC_W-1:0] TIME_MIN_8K  = 12'h006;
   localparam logic [ACC_W-1:0] TIME_MIN_5K  = 12'h005;
   localparam logic [SPEED_W-1:0] UPPER_11K  = 16'h2AF8; // 11000
   localparam logic [SPEED_W-1:0] UPPER_8K   = 16'h1F40; // 8000
   localparam logic [SPEED_W-1:0] UPPER_5K   = 16'h1388; // 5000

   // Rate format limits, pps per 10 ms
   localparam logic [ACC_W-1:0] RATE_MIN = 12'h001;
   localparam logic [ACC_W-1:0] RATE_MAX = 12'h606; // 1542
   localparam int MIN_TRANSITION_MS = 80;
   localparam int MIN_STEPS = MIN_TRANSITION_MS / TIME_STEP_MS;
   localparam logic [SPEED_W-1:0] WIDTH_MIN = 16'h0020; // 32

   // Instruction codes
   typedef enum logic [2:0] {
      INS_NONE       = 3'h0,
      INS_LOWER      = 3'h1,
      INS_UPPER      = 3'h2,
      INS_ACCELERATE = 3'h3,
      INS_DECELERATE = 3'h4,
      INS_DECEL_STOP = 3'h5,
      INS_PATTERN    = 3'h6
   } instruction_t;

   // Effective parameter word indices
   localparam logic [1:0] EFF_LOWER = 2'h0;
   localparam logic [1:0] EFF_UPPER = 2'h1;
   localparam logic [1:0] EFF_RISE  = 2'h2;
   localparam logic [1:0] EFF_FALL  = 2'h3;

   // Status and interrupt bits
   localparam int ST_BUSY        = 0;
   localparam int ST_ERROR       = 1;
   localparam int ST_ERR_SPEED   = 2;
   localparam int ST_ERR_ACCEL   = 3;
   localparam int ST_ERR_WIDTH   = 4;
   localparam int ST_CORRECTED   = 5;
   localparam int ST_NO_TRANSIT  = 6;
   localparam int IRQ_ACCEPT     = 0;
   localparam int IRQ_REJECT     = 1;
endpackage : accel_check_pkg

/* File: param_store.sv */
// Purpose: Four-word store of the corrected parameter set
// Assumes: One write port, one read port, same clock
// Notes:   Read data is registered, one cycle after the address
module param_store (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [1:0]  wr_addr,
   input  wire logic [15:0] wr_data,
   input  wire logic [1:0]  rd_addr,
   output logic      [15:0] rd_data
);
   logic [15:0] words [4];

   generate
      for (genvar i = 0; i < 4; i++) begin : g_word
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               words[i] <= 16'h0000;
            end else if (wr_en && wr_addr == 2'(i)) begin
               words[i] <= wr_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 16'h0000;
      end else begin
         rd_data <= words[rd_addr];
      end
   end
endmodule : param_store

/* File: accel_param_validation.sv */
// Purpose: Checks and corrects speed and acceleration settings on issue
// Assumes: APB master, 20 MHz clk, asynchronous active-low rstn
// Notes:   Accepted instructions leave as a one-cycle issue pulse

// Notes on behaviour
// - Format bit set means times; clear (default) means rates.
// - In time format, one count is one 10 ms transition step.
// - Rising and falling settings are kept apart in both formats.
// - Time format accepts 8 to 4095 counts at any upper speed.
// - Minimum drops to 7, 6, 5 at upper speeds of 11k, 8k, 5k.
// - Bad acceleration on accelerate, decelerate, decel-stop or pattern errors when correction is off.
// - Bad lower or upper speed errors when correction is off.
// - With correction on, bad values are brought into range, no error.
// - Low lower speed with correction becomes the range minimum.
// - Accelerate, decelerate, decel-stop error on width under 32 always.
// - Pattern move with narrow width and correction runs flat at lower.
// - Correction enable bit, set after reset.
// - Range 2 is default, spanning 160 pps to 12.5 kpps.
// - Rate format under 80 ms with correction forces at least 80 ms, the rate rounded down.
module accel_param_validation (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             issue_valid,
   output logic      [2:0]  issue_code,
   output logic             issue_no_transition
);
   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_CHECK = 2'b01,
      S_STORE = 2'b10,
      S_ISSUE = 2'b11
   } state_t;

   logic        rst_meta;
   logic        rst_n;
   state_t      state;
   logic [1:0]  store_idx;

   logic        format_time;
   logic        auto_correct;
   logic [1:0]  speed_range;
   logic [15:0] lower_speed;
   logic [15:0] upper_speed;
   logic [11:0] rise_setting;
   logic [11:0] fall_setting;
   logic [2:0]  pending_code;
   logic [6:0]  status;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;

   logic [15:0] eff_lower;
   logic [15:0] eff_upper;
   logic [11:0] eff_rise;
   logic [11:0] eff_fall;
   logic [15:0] mem_rdata;
   logic [15:0] store_data;

   logic        access;
   logic        wr_now;
   logic        insn_write;
   logic        ev_accept;
   logic        ev_reject;

   logic [15:0] next_lower;
   logic [15:0] next_upper;
   logic [11:0] next_rise;
   logic [11:0] next_fall;
   logic        bad_speed;
   logic        bad_accel;
   logic        narrow;
   logic        reject;
   logic        flat_move;
   logic        flat_held;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   function automatic logic [15:0] range_min(input logic [1:0] r);
      case (r)
         2'h0:    range_min = accel_check_pkg::RANGE0_MIN;
         2'h1:    range_min = accel_check_pkg::RANGE1_MIN;
         default: range_min = accel_check_pkg::RANGE2_MIN;
      endcase
   endfunction : range_min

   function automatic logic [15:0] range_max(input logic [1:0] r);
      case (r)
         2'h0:    range_max = accel_check_pkg::RANGE0_MAX;
         2'h1:    range_max = accel_check_pkg::RANGE1_MAX;
         default: range_max = accel_check_pkg::RANGE2_MAX;
      endcase
   endfunction : range_max

   // Clamp a speed into the range; top bit flags a change
   function automatic logic [16:0] clamp_speed(input logic [15:0] v,
                                               input logic [1:0]  r);
      if (v < range_min(r)) begin
         clamp_speed = {1'b1, range_min(r)};
      end else if (v > range_max(r)) begin
         clamp_speed = {1'b1, range_max(r)};
      end else begin
         clamp_speed = {1'b0, v};
      end
   endfunction : clamp_speed

   // Correct one acceleration setting; top bit flags a change
   function automatic logic [12:0] fix_accel(input logic [11:0] v,
                                             input logic        tfmt,
                                             input logic [15:0] up,
                                             input logic [15:0] width);
      logic [11:0] tmin;
      logic [11:0] rate;
      logic [31:0] span;
      tmin = accel_check_pkg::TIME_MIN_ANY;
      rate = v;
      span = 32'(v) * 32'(accel_check_pkg::MIN_STEPS);
      if (up <= accel_check_pkg::UPPER_5K) begin
         tmin = accel_check_pkg::TIME_MIN_5K;
      end else if (up <= accel_check_pkg::UPPER_8K) begin
         tmin = accel_check_pkg::TIME_MIN_8K;
      end else if (up <= accel_check_pkg::UPPER_11K) begin
         tmin = accel_check_pkg::TIME_MIN_11K;
      end
      if (tfmt) begin
         // 12-bit field cannot exceed the 4095 count ceiling
         fix_accel = (v < tmin) ? {1'b1, tmin} : {1'b0, v};
      end else if (v < accel_check_pkg::RATE_MIN) begin
         fix_accel = {1'b1, accel_check_pkg::RATE_MIN};
      end else if (v > accel_check_pkg::RATE_MAX) begin
         fix_accel = {1'b1, accel_check_pkg::RATE_MAX};
      end else if (32'(width) < span) begin
         // Largest rate giving at least the minimum transition time
         rate = 12'(width / 16'(accel_check_pkg::MIN_STEPS));
         if (rate < accel_check_pkg::RATE_MIN) begin
            rate = accel_check_pkg::RATE_MIN;
         end
         fix_accel = {1'b1, rate};
      end else begin
         fix_accel = {1'b0, v};
      end
   endfunction : fix_accel

   function automatic logic uses_accel(input logic [2:0] c);
      uses_accel = (c == accel_check_pkg::INS_ACCELERATE) ||
                   (c == accel_check_pkg::INS_DECELERATE) ||
                   (c == accel_check_pkg::INS_DECEL_STOP) ||
                   (c == accel_check_pkg::INS_PATTERN);
   endfunction : uses_accel

   // Check and correction of the pending instruction
   always_comb begin
      logic [16:0] lo_fix;
      logic [16:0] up_fix;
      logic [12:0] rise_fix;
      logic [12:0] fall_fix;
      logic [15:0] width;
      lo_fix   = clamp_speed(lower_speed, speed_range);
      up_fix   = clamp_speed(upper_speed, speed_range);
      width    = (up_fix[15:0] > lo_fix[15:0]) ?
                 (up_fix[15:0] - lo_fix[15:0]) : 16'h0000;
      rise_fix = fix_accel(rise_setting, format_time, up_fix[15:0],
                           width);
      fall_fix = fix_accel(fall_setting, format_time, up_fix[15:0],
                           width);
      next_lower = lo_fix[15:0];
      next_upper = up_fix[15:0];
      next_rise  = rise_fix[11:0];
      next_fall  = fall_fix[11:0];
      bad_speed  = lo_fix[16] | up_fix[16] |
                   (upper_speed < lower_speed);
      bad_accel  = uses_accel(pending_code) & (rise_fix[12] | fall_fix[12]);
      narrow     = uses_accel(pending_code) &
                   (width < accel_check_pkg::WIDTH_MIN);
      flat_move  = narrow &&
                   pending_code == accel_check_pkg::INS_PATTERN;
      if (narrow && !flat_move) begin
         reject = 1'b1;
      end else if (!auto_correct) begin
         reject = bad_speed | bad_accel | flat_move;
      end else begin
         reject = 1'b0;
      end
   end

   assign access     = psel & penable & ~pready;
   // Writes land at the answer edge, where the master samples pready
   assign wr_now     = psel & penable & pready & pwrite;
   assign insn_write = wr_now && paddr == accel_check_pkg::OFS_INSTRUCTION;
   assign ev_accept  = state == S_STORE &&
                       store_idx == accel_check_pkg::EFF_FALL;
   assign ev_reject  = state == S_CHECK && reject;

   // Property group two and setting registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         format_time  <= 1'b0;
         auto_correct <= 1'b1;
         speed_range  <= accel_check_pkg::RANGE_DEFAULT;
         lower_speed  <= 16'h0000;
         upper_speed  <= 16'h0000;
         rise_setting <= 12'h000;
         fall_setting <= 12'h000;
      end else if (wr_now) begin
         case (paddr)
            accel_check_pkg::OFS_PROPERTY_GROUP_TWO: begin
               format_time  <= pwdata[accel_check_pkg::BIT_FORMAT_SELECT];
               auto_correct <= pwdata[accel_check_pkg::BIT_AUTO_CORRECT];
               speed_range  <= pwdata[accel_check_pkg::RANGE_LSB +: 2];
            end
            accel_check_pkg::OFS_LOWER_SPEED:  lower_speed  <= pwdata[15:0];
            accel_check_pkg::OFS_UPPER_SPEED:  upper_speed  <= pwdata[15:0];
            accel_check_pkg::OFS_RISE_SETTING: rise_setting <= pwdata[11:0];
            accel_check_pkg::OFS_FALL_SETTING: fall_setting <= pwdata[11:0];
            default: ;
         endcase
      end
   end

   // Instruction sequencing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state        <= S_IDLE;
         store_idx    <= 2'h0;
         pending_code <= accel_check_pkg::INS_NONE;
      end else begin
         case (state)
            S_IDLE: begin
               // Instruction writes while busy are dropped
               if (insn_write &&
                   pwdata[2:0] != accel_check_pkg::INS_NONE) begin
                  pending_code <= pwdata[2:0];
                  state        <= S_CHECK;
               end
            end
            S_CHECK: begin
               store_idx <= accel_check_pkg::EFF_LOWER;
               state     <= reject ? S_IDLE : S_STORE;
            end
            S_STORE: begin
               store_idx <= store_idx + 2'h1;
               if (store_idx == accel_check_pkg::EFF_FALL) begin
                  state <= S_ISSUE;
               end
            end
            S_ISSUE: state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // Corrected values held steady while they are stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eff_lower <= 16'h0000;
         eff_upper <= 16'h0000;
         eff_rise  <= 12'h000;
         eff_fall  <= 12'h000;
         flat_held <= 1'b0;
      end else if (state == S_CHECK && !reject) begin
         eff_lower <= next_lower;
         eff_upper <= next_upper;
         eff_rise  <= next_rise;
         eff_fall  <= next_fall;
         flat_held <= flat_move;
      end
   end

   always_comb begin
      case (store_idx)
         accel_check_pkg::EFF_LOWER: store_data = eff_lower;
         accel_check_pkg::EFF_UPPER: store_data = eff_upper;
         accel_check_pkg::EFF_RISE:  store_data = {4'h0, eff_rise};
         default:                    store_data = {4'h0, eff_fall};
      endcase
   end

   param_store u_store (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (state == S_STORE),
      .wr_addr (store_idx),
      .wr_data (store_data),
      .rd_addr (paddr[3:2]),
      .rd_data (mem_rdata)
   );

   // Issue outputs: only accepted instructions reach the generator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         issue_valid         <= 1'b0;
         issue_code          <= accel_check_pkg::INS_NONE;
         issue_no_transition <= 1'b0;
      end else begin
         issue_valid <= ev_accept;
         // Code and flag move only together with their pulse
         if (ev_accept) begin
            issue_code          <= pending_code;
            issue_no_transition <= flat_held;
         end
      end
   end

   // Status of the last checked instruction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= 7'h00;
      end else begin
         status[accel_check_pkg::ST_BUSY] <= next_busy(state, insn_write,
                                                       pwdata[2:0]);
         if (state == S_CHECK) begin
            status[accel_check_pkg::ST_ERROR]      <= reject;
            status[accel_check_pkg::ST_ERR_SPEED]  <= bad_speed;
            status[accel_check_pkg::ST_ERR_ACCEL]  <= bad_accel;
            status[accel_check_pkg::ST_ERR_WIDTH]  <= narrow;
            status[accel_check_pkg::ST_CORRECTED]  <= ~reject &
                                                      (bad_speed | bad_accel);
            status[accel_check_pkg::ST_NO_TRANSIT] <= ~reject & flat_move;
         end
      end
   end

   function automatic logic next_busy(input state_t s, input logic w,
                                      input logic [2:0] c);
      case (s)
         S_IDLE:  next_busy = w && c != accel_check_pkg::INS_NONE;
         S_ISSUE: next_busy = 1'b0;
         S_CHECK: next_busy = 1'b1;
         default: next_busy = 1'b1;
      endcase
   endfunction : next_busy

   // Sticky events, write one to clear; a new event beats the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= 2'h0;
         irq_mask   <= 2'h0;
         irq        <= 1'b0;
      end else begin
         if (wr_now && paddr == accel_check_pkg::OFS_IRQ_STATUS) begin
            irq_status <= (irq_status & ~pwdata[1:0]) |
                          {ev_reject, ev_accept};
         end else begin
            irq_status <= irq_status | {ev_reject, ev_accept};
         end
         if (wr_now && paddr == accel_check_pkg::OFS_IRQ_MASK) begin
            irq_mask <= pwdata[1:0];
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // APB answer: one wait state on every access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (access) begin
            case (paddr)
               accel_check_pkg::OFS_PROPERTY_GROUP_TWO:
                  prdata <= {28'h0, speed_range, auto_correct, format_time};
               accel_check_pkg::OFS_LOWER_SPEED:
                  prdata <= {16'h0, lower_speed};
               accel_check_pkg::OFS_UPPER_SPEED:
                  prdata <= {16'h0, upper_speed};
               accel_check_pkg::OFS_RISE_SETTING:
                  prdata <= {20'h0, rise_setting};
               accel_check_pkg::OFS_FALL_SETTING:
                  prdata <= {20'h0, fall_setting};
               accel_check_pkg::OFS_INSTRUCTION:
                  prdata <= {29'h0, pending_code};
               accel_check_pkg::OFS_STATUS:
                  prdata <= {25'h0, status};
               accel_check_pkg::OFS_IRQ_STATUS:
                  prdata <= {30'h0, irq_status};
               accel_check_pkg::OFS_IRQ_MASK:
                  prdata <= {30'h0, irq_mask};
               default: begin
                  if ((paddr & accel_check_pkg::EFFECTIVE_MASK) ==
                      accel_check_pkg::OFS_EFFECTIVE_BASE) begin
                     if (!pwrite) begin
                        prdata <= {16'h0, mem_rdata};
                     end
                  end else begin
                     pslverr <= 1'b1;
                  end
               end
            endcase
         end
      end
   end
endmodule : accel_param_validation

/* File: accel_param_validation_asserts.sv */
// Purpose: Port-level checks of the parameter checker
// Assumes: One clock, rstn active low
// Notes:   Bound to every accel_param_validation instance
module apv_check (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        issue_valid,
   input wire logic [2:0]  issue_code,
   input wire logic        issue_no_transition
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_ready_next: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_unmapped_err: assert property (pready && paddr[7:6] != 2'h0 |-> pslverr)
      else $error("unmapped address accepted");
   a_mapped_ok: assert property (pready && paddr <= 8'h20
      && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped address refused");
   a_idle_data: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata outside answer");
   a_issue_pulse: assert property (issue_valid |=> !issue_valid)
      else $error("issue pulse too long");
   a_issue_cause: assert property (issue_valid |-> $past(psel && penable
      && pwrite && paddr == 8'h14, 7)) else $error("issue without write");
   a_code_hold: assert property (!issue_valid |-> $stable(issue_code))
      else $error("issue code moved without issue");
   a_flat_pattern: assert property (issue_no_transition
      |-> issue_code == accel_check_pkg::INS_PATTERN) else $error("flat move");
endmodule : apv_check

bind accel_param_validation apv_check chk_i (.clk(clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq(irq), .issue_valid(issue_valid), .issue_code(issue_code),
   .issue_no_transition(issue_no_transition));

/* File: apb_host.sv */
// Purpose: Host controller model driving the register bus
// Assumes: Slave answers with pready; no wait bound here
// Notes:   Bench timeout cuts a missing answer short
module apb_host (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : apb_host

/* File: tb.sv */
// Purpose: Self-checking bench for the parameter checker
// Assumes: apb_host drives the register bus
// Notes:   Outcome judged by issue pulses and irq status
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, irq, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        issue_valid, issue_no_transition;
   logic [2:0]  issue_code, last_code = 3'h0;
   int          mismatches = 0, checks_done = 0, pulses = 0, cycles = 0;
   int          ups[4] = '{5000, 8000, 11000, 12500};
   localparam logic [7:0] EB = accel_check_pkg::OFS_EFFECTIVE_BASE;
   always #25 clk = ~clk;
   apb_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   accel_param_validation uut (.clk(clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .issue_valid(issue_valid), .issue_code(issue_code),
      .issue_no_transition(issue_no_transition));
   task automatic complete_run;
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   // Run takes about 780 cycles; ceiling leaves margin
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (issue_valid === 1'b1) pulses <= pulses + 1;
      if (cycles == 8000) begin
         mismatches = mismatches + 1;
         complete_run;
      end
   end
   task automatic chk(input logic [31:0] seen, exp, input string name);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x, string n);
      host.xfer(1'b0, a, 32'h0, q, e);
      chk(q, x, n);
   endtask : rd
   task automatic setp(input logic [31:0] g, lo, up, ri, fa);
      wr(accel_check_pkg::OFS_PROPERTY_GROUP_TWO, g);
      wr(accel_check_pkg::OFS_LOWER_SPEED, lo);
      wr(accel_check_pkg::OFS_UPPER_SPEED, up);
      wr(accel_check_pkg::OFS_RISE_SETTING, ri);
      wr(accel_check_pkg::OFS_FALL_SETTING, fa);
   endtask : setp
   // Fixed wait covers both answer times; accepted irq is masked off
   task automatic run(input logic [2:0] c, input logic ok);
      int n0;
      n0 = pulses;
      wr(accel_check_pkg::OFS_INSTRUCTION, {29'h0, c});
      repeat (12) @(posedge clk);
      if (ok) last_code = c;
      chk(32'(pulses - n0), {31'h0, ok}, "issue count");
      chk({29'h0, issue_code}, {29'h0, last_code}, "issue code");
      chk({31'h0, irq}, {31'h0, !ok}, "irq");
      rd(accel_check_pkg::OFS_IRQ_STATUS, ok ? 32'h1 : 32'h2, "irq status");
      wr(accel_check_pkg::OFS_IRQ_STATUS, 32'h3);
      repeat (2) @(posedge clk); // Level trails the cleared bit
      chk({31'h0, irq}, 32'h0, "irq cleared");
   endtask : run
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(accel_check_pkg::OFS_PROPERTY_GROUP_TWO, 32'hA, "pg2");
      host.xfer(1'b0, 8'h40, 32'h0, q, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      wr(accel_check_pkg::OFS_IRQ_MASK, 32'h2);
      setp(32'hA, 40, 1000, 10, 20);
      run(3'h1, 1'b1);
      rd(EB, 32'hA0, "eff lower");
      setp(32'hA, 160, 1000, 1542, 1);
      run(3'h3, 1'b1);
      rd(EB + 8'h8, 32'h69, "eff rise");
      rd(EB + 8'hC, 32'h1, "eff fall");
      rd(accel_check_pkg::OFS_STATUS, 32'h28, "status");
      setp(32'h8, 40, 1000, 10, 10);
      run(3'h1, 1'b0);
      setp(32'h8, 160, 1000, 0, 10);
      run(3'h3, 1'b0);
      setp(32'hA, 500, 510, 10, 10);
      for (int c = 3; c < 6; c++) run(3'(c), 1'b0);
      run(3'h6, 1'b1);
      chk({31'h0, issue_no_transition}, 32'h1, "flat move");
      for (int i = 0; i < 4; i++) begin
         setp(32'h9, 500, ups[i], 5 + i, 5 + i);
         run(3'h3, 1'b1);
         rd(EB + 8'h8, 32'(5 + i), "eff time");
         setp(32'h9, 500, ups[i], 4 + i, 9);
         run(3'h3, 1'b0);
      end
      setp(32'h9, 500, 12500, 4095, 4095);
      run(3'h3, 1'b1);
      complete_run;
   end
endmodule : tb
